// ---- rtl/mptc_pkg.sv ----
// Shared constants for the module power and thermal control block
package mptc_pkg;

  // ----------------------------------------------------------------
  // Page-two byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INS_COUNT_LOW   = 8'h8D;
  localparam logic [7:0] ADDR_INS_COUNT_HIGH  = 8'h8E;
  localparam logic [7:0] ADDR_STAGE_DLY_HIGH  = 8'h8F;
  localparam logic [7:0] ADDR_STAGE_DLY_LOW   = 8'h90;
  localparam logic [7:0] ADDR_RESET_PIN_LVL   = 8'h91;
  localparam logic [7:0] ADDR_LOW_POWER_LVL   = 8'h92;
  localparam logic [7:0] ADDR_INT_PIN_LVL     = 8'h93;

  // ----------------------------------------------------------------
  // Reset values and read codes
  // ----------------------------------------------------------------
  localparam logic [7:0] STAGE_DLY_RESET      = 8'h00;
  localparam logic [7:0] RESET_LOW_READ       = 8'hFF;
  localparam logic [7:0] BYTE_ZERO            = 8'h00;

  // ----------------------------------------------------------------
  // Power setting byte layout
  // ----------------------------------------------------------------
  localparam int         PWM_DUTY_LSB         = 0;
  localparam int         PWM_DUTY_W           = 6;
  localparam int         SPOT_A_BIT           = 6;
  localparam int         SPOT_B_BIT           = 7;

  // ----------------------------------------------------------------
  // Thermal limits, 1/256 degree units
  // ----------------------------------------------------------------
  localparam int         CUTOFF_DEG           = 80;
  localparam int         HYST_DEG             = 5;
  localparam int         TEMP_FRAC            = 256;
  localparam logic signed [15:0] CUTOFF_TEMP  = 16'(CUTOFF_DEG * TEMP_FRAC);
  localparam logic signed [15:0] RESTORE_TEMP = 16'((CUTOFF_DEG - HYST_DEG) * TEMP_FRAC);

  // ----------------------------------------------------------------
  // Staging step and timing
  // ----------------------------------------------------------------
  localparam int         STEP_PERCENT         = 5;
  localparam int         FULL_SCALE           = 255;
  localparam logic [7:0] STAGE_STEP           = 8'((FULL_SCALE * STEP_PERCENT + 99) / 100);
  localparam int         CLK_PERIOD_NS        = 100;
  localparam int         DELAY_UNIT_NS        = 1000;
  localparam int         TICK_CYCLES          = DELAY_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Start-up sequence states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    INIT_LOAD  = 2'b00,
    INIT_STORE = 2'b01,
    RUNNING    = 2'b10
  } mptc_init_t;

endpackage

// ---- rtl/mptc_pwm.sv ----
// Free-running PWM for the proportional heater spot
`timescale 1ns/10ps
module mptc_pwm #(
  parameter int DUTY_W = 6
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  // Control
  input  wire logic              enable,
  input  wire logic [DUTY_W-1:0] duty,
  // Output
  output logic                   pwm_out
);

  logic [DUTY_W-1:0] phase_reg;
  logic              pwm_next;

  assign pwm_next = enable && (phase_reg < duty);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= '0;
      pwm_out   <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 1'b1;
      pwm_out   <= pwm_next;
    end
  end

endmodule

// ---- rtl/mptc_top.sv ----
// Heater power control, cut-off, staging, insertion count and pin mirrors
`timescale 1ns/10ps

module mptc_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Page-two byte access
  input  wire logic        page_two_sel,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // Power control inputs
  input  wire logic [7:0]  power_setting,
  input  wire logic        power_override,
  input  wire logic        power_set,
  input  wire logic signed [15:0] temp_reading,
  // Low-speed pins
  input  wire logic        module_reset_pin_n,
  input  wire logic        low_power_pin,
  input  wire logic        interrupt_pin_n_in,
  output logic             interrupt_pin_n_out,
  output logic             interrupt_pin_n_oe_n,
  // Nonvolatile counter storage
  input  wire logic [15:0] nv_count_in,
  output logic [15:0]      nv_count_out,
  output logic             nv_write,
  // Heater drive
  output logic             heater_pwm,
  output logic             heater_spot_a,
  output logic             heater_spot_b,
  output logic             cutoff_active
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mptc_pkg::mptc_init_t init_reg;
  mptc_pkg::mptc_init_t init_next;
  logic [15:0] ins_count_reg;
  logic [7:0]  dly_high_reg;
  logic [7:0]  dly_low_reg;
  logic [15:0] active_dly_reg;
  logic        reset_pin_prev_reg;
  logic        int_drive_low_reg;
  logic        cutoff_reg;
  logic [7:0]  applied_reg;
  logic [7:0]  applied_next;
  logic [3:0]  tick_cnt_reg;
  logic        tick_us;
  logic [15:0] wait_cnt_reg;
  logic        int_n_out_next;
  logic        int_n_oe_next;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_dly_high = page_two_sel && reg_wr && (reg_addr == mptc_pkg::ADDR_STAGE_DLY_HIGH);
  wire wr_dly_low  = page_two_sel && reg_wr && (reg_addr == mptc_pkg::ADDR_STAGE_DLY_LOW);
  wire wr_int_pin  = page_two_sel && reg_wr && (reg_addr == mptc_pkg::ADDR_INT_PIN_LVL);
  wire running     = (init_reg == mptc_pkg::RUNNING);
  wire reset_rise  = module_reset_pin_n && !reset_pin_prev_reg;

  // Resolved power state
  wire low_power   = power_override ? power_set : low_power_pin;

  // Cut-off comparison on the signed monitor reading
  wire temp_hot    = (temp_reading >= mptc_pkg::CUTOFF_TEMP);
  wire temp_cool   = (temp_reading <= mptc_pkg::RESTORE_TEMP);

  // Target and staging
  wire [7:0] target       = low_power ? mptc_pkg::BYTE_ZERO : power_setting;
  wire       staging_on   = (active_dly_reg != 16'h0000);
  wire [8:0] step_sum     = {1'b0, applied_reg} + {1'b0, mptc_pkg::STAGE_STEP};
  wire [7:0] step_clamped = (step_sum >= {1'b0, target}) ? target : step_sum[7:0];
  wire       step_due     = tick_us && (wait_cnt_reg + 16'h0001 >= active_dly_reg);
  wire [7:0] drive_level  = cutoff_reg ? mptc_pkg::BYTE_ZERO : applied_reg;

  // Read mux
  wire [7:0] rd_reset_lvl = module_reset_pin_n ? 8'h01 : mptc_pkg::RESET_LOW_READ;
  wire [7:0] rd_lp_lvl    = {7'h00, low_power_pin};
  wire [7:0] rd_int_lvl   = {7'h00, interrupt_pin_n_in};
  logic [7:0] rd_sel;

  always_comb begin
    unique case (reg_addr)
      mptc_pkg::ADDR_INS_COUNT_LOW:  rd_sel = ins_count_reg[7:0];
      mptc_pkg::ADDR_INS_COUNT_HIGH: rd_sel = ins_count_reg[15:8];
      mptc_pkg::ADDR_STAGE_DLY_HIGH: rd_sel = dly_high_reg;
      mptc_pkg::ADDR_STAGE_DLY_LOW:  rd_sel = dly_low_reg;
      mptc_pkg::ADDR_RESET_PIN_LVL:  rd_sel = rd_reset_lvl;
      mptc_pkg::ADDR_LOW_POWER_LVL:  rd_sel = rd_lp_lvl;
      mptc_pkg::ADDR_INT_PIN_LVL:    rd_sel = rd_int_lvl;
      default:                       rd_sel = mptc_pkg::BYTE_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // Start-up sequence
  // ----------------------------------------------------------------
  always_comb begin
    init_next = init_reg;
    unique case (init_reg)
      mptc_pkg::INIT_LOAD:  init_next = mptc_pkg::INIT_STORE;
      mptc_pkg::INIT_STORE: init_next = mptc_pkg::RUNNING;
      mptc_pkg::RUNNING:    init_next = mptc_pkg::RUNNING;
      default:              init_next = mptc_pkg::INIT_LOAD;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_reg <= mptc_pkg::INIT_LOAD;
    end else begin
      init_reg <= init_next;
    end
  end

  // Counter loaded from storage, bumped and written back
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ins_count_reg <= 16'h0000;
      nv_count_out  <= 16'h0000;
      nv_write      <= 1'b0;
    end else begin
      nv_write <= 1'b0;
      if (init_reg == mptc_pkg::INIT_LOAD) begin
        ins_count_reg <= nv_count_in + 16'h0001;
      end
      if (init_reg == mptc_pkg::INIT_STORE) begin
        nv_count_out <= ins_count_reg;
        nv_write     <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable bytes and delay capture
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_high_reg <= mptc_pkg::STAGE_DLY_RESET;
      dly_low_reg  <= mptc_pkg::STAGE_DLY_RESET;
    end else begin
      if (wr_dly_high) begin
        dly_high_reg <= reg_wdata;
      end
      if (wr_dly_low) begin
        dly_low_reg <= reg_wdata;
      end
    end
  end

  // Delay in force changes only at start-up or module reset release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_dly_reg     <= {mptc_pkg::STAGE_DLY_RESET, mptc_pkg::STAGE_DLY_RESET};
      reset_pin_prev_reg <= 1'b1;
    end else begin
      reset_pin_prev_reg <= module_reset_pin_n;
      if (!running || reset_rise) begin
        active_dly_reg <= {dly_high_reg, dly_low_reg};
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin test drive
  // ----------------------------------------------------------------
  assign int_n_out_next = 1'b0;
  assign int_n_oe_next  = !int_drive_low_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_drive_low_reg    <= 1'b0;
      interrupt_pin_n_out  <= 1'b0;
      interrupt_pin_n_oe_n <= 1'b1;
    end else begin
      if (wr_int_pin) begin
        int_drive_low_reg <= !reg_wdata[0];
      end
      interrupt_pin_n_out  <= int_n_out_next;
      interrupt_pin_n_oe_n <= int_n_oe_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= mptc_pkg::BYTE_ZERO;
    end else if (page_two_sel && reg_rd) begin
      reg_rdata <= rd_sel;
    end
  end

  // ----------------------------------------------------------------
  // Over-temperature cut-off with hysteresis
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cutoff_reg <= 1'b0;
    end else if (temp_hot) begin
      cutoff_reg <= 1'b1;
    end else if (temp_cool) begin
      cutoff_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Microsecond tick and stage timer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= 4'h0;
      tick_us      <= 1'b0;
    end else if (tick_cnt_reg == 4'(mptc_pkg::TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 4'h0;
      tick_us      <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 4'h1;
      tick_us      <= 1'b0;
    end
  end

  // Applied level: drops at once, rises by staged steps
  always_comb begin
    applied_next = applied_reg;
    if (!running) begin
      applied_next = mptc_pkg::BYTE_ZERO;
    end else if (target <= applied_reg || !staging_on) begin
      applied_next = target;
    end else if (!cutoff_reg && step_due) begin
      applied_next = step_clamped;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      applied_reg  <= mptc_pkg::BYTE_ZERO;
      wait_cnt_reg <= 16'h0000;
    end else begin
      applied_reg <= applied_next;
      if (applied_next != applied_reg || target <= applied_reg) begin
        wait_cnt_reg <= 16'h0000;
      end else if (tick_us && !cutoff_reg) begin
        wait_cnt_reg <= wait_cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Heater outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      heater_spot_a <= 1'b0;
      heater_spot_b <= 1'b0;
      cutoff_active <= 1'b0;
    end else begin
      heater_spot_a <= drive_level[mptc_pkg::SPOT_A_BIT];
      heater_spot_b <= drive_level[mptc_pkg::SPOT_B_BIT];
      cutoff_active <= cutoff_reg;
    end
  end

  mptc_pwm #(
    .DUTY_W (mptc_pkg::PWM_DUTY_W)
  ) u_pwm (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .enable  (!cutoff_reg),
    .duty    (drive_level[mptc_pkg::PWM_DUTY_LSB +: mptc_pkg::PWM_DUTY_W]),
    .pwm_out (heater_pwm)
  );

endmodule

// ---- bench/mptc_far_model.sv ----
// Far-side model: count store and pulled-up interrupt wire
`timescale 1ns/10ps
module mptc_far_model #(
  parameter logic [15:0] START_COUNT = 16'h01FE
) (
  // Clock
  input  logic        ref_clk,
  // Count store
  input  logic        nv_write,
  input  logic [15:0] nv_count_out,
  output logic [15:0] nv_count_in,
  // Interrupt pin
  input  logic        int_out,
  input  logic        int_oe_n,
  output logic        int_wire
);
  logic [15:0] store_reg = START_COUNT;

  // No reset term: survives module resets
  always @(posedge ref_clk) begin
    if (nv_write) store_reg <= nv_count_out;
  end
  assign nv_count_in = store_reg;
  // Released wire floats high by pull-up
  assign int_wire = int_oe_n ? 1'b1 : int_out;
endmodule

// ---- bench/mptc_assertions.sv ----
// Port checker of the heater and pin control block
`timescale 1ns/10ps
module mptc_checker (
  // Clock and reset
  input logic               ref_clk,
  input logic               arst_n,
  // Register access
  input logic               page_two_sel,
  input logic [7:0]         reg_addr,
  input logic               reg_wr,
  input logic [7:0]         reg_wdata,
  input logic               reg_rd,
  input logic [7:0]         reg_rdata,
  // Power and pins
  input logic               power_override,
  input logic               power_set,
  input logic signed [15:0] temp_reading,
  input logic               module_reset_pin_n,
  input logic               low_power_pin,
  input logic               interrupt_pin_n_in,
  input logic               interrupt_pin_n_oe_n,
  // Count store and heater
  input logic [15:0]        nv_count_in,
  input logic [15:0]        nv_count_out,
  input logic               nv_write,
  input logic               heater_pwm,
  input logic               heater_spot_a,
  input logic               heater_spot_b,
  input logic               cutoff_active
);
  logic [1:0] up_cnt_reg;
  wire        run = up_cnt_reg == 2'h3;
  wire        rd2 = page_two_sel && reg_rd;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) up_cnt_reg <= 2'h0;
    else if (!run) up_cnt_reg <= up_cnt_reg + 2'h1;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_cut_next: assert property (run && $past(run) |-> cutoff_active == ($past(temp_reading, 2) >= mptc_pkg::CUTOFF_TEMP
    || ($past(cutoff_active) && $past(temp_reading, 2) > mptc_pkg::RESTORE_TEMP))) else $error("cut-off state wrong");
  a_cut_dark: assert property (cutoff_active [*4] |-> !heater_spot_a && !heater_spot_b && !heater_pwm)
    else $error("heater on during cut-off");
  a_low_power_off: assert property ((power_override ? power_set : low_power_pin) [*6]
    |-> !heater_spot_a && !heater_spot_b && !heater_pwm) else $error("heater on in low power");
  a_rd_reset: assert property (rd2 && reg_addr == mptc_pkg::ADDR_RESET_PIN_LVL
    |=> reg_rdata == ($past(module_reset_pin_n) ? 8'h01 : 8'hFF)) else $error("reset pin byte wrong");
  a_rd_lowpow: assert property (rd2 && reg_addr == mptc_pkg::ADDR_LOW_POWER_LVL
    |=> reg_rdata == {7'h00, $past(low_power_pin)}) else $error("low power byte wrong");
  a_rd_intpin: assert property (rd2 && reg_addr == mptc_pkg::ADDR_INT_PIN_LVL
    |=> reg_rdata == {7'h00, $past(interrupt_pin_n_in)}) else $error("interrupt byte wrong");
  a_int_drive: assert property (page_two_sel && reg_wr && reg_addr == mptc_pkg::ADDR_INT_PIN_LVL && !reg_wdata[0]
    |-> ##[1:3] !interrupt_pin_n_oe_n) else $error("interrupt pin not driven low");
  a_count_once: assert property (nv_write == (up_cnt_reg == 2'h2))
    else $error("count store pulse wrong");
  a_count_value: assert property (nv_write |-> nv_count_out == $past(nv_count_in, 2) + 16'h0001)
    else $error("stored count not one more");

  c_cut: cover property ($rose(cutoff_active));
  c_store: cover property (nv_write);
  c_int: cover property ($fell(interrupt_pin_n_oe_n));
endmodule

bind mptc_top mptc_checker chk_i (
  .ref_clk(ref_clk), .arst_n(arst_n), .page_two_sel(page_two_sel), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_override(power_override),
  .power_set(power_set), .temp_reading(temp_reading), .module_reset_pin_n(module_reset_pin_n),
  .low_power_pin(low_power_pin), .interrupt_pin_n_in(interrupt_pin_n_in), .interrupt_pin_n_oe_n(interrupt_pin_n_oe_n),
  .nv_count_in(nv_count_in), .nv_count_out(nv_count_out), .nv_write(nv_write), .heater_pwm(heater_pwm),
  .heater_spot_a(heater_spot_a), .heater_spot_b(heater_spot_b), .cutoff_active(cutoff_active)
);

// ---- bench/tb.sv ----
// Directed bench of the heater and pin control block
`timescale 1ns/10ps
module tb;
  logic               ref_clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               page_two_sel = 1'b1;
  logic [7:0]         reg_addr = 8'h00;
  logic               reg_wr = 1'b0;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_rd = 1'b0;
  logic [7:0]         reg_rdata, power_setting = 8'h00;
  logic               power_override = 1'b0;
  logic               power_set = 1'b0;
  logic signed [15:0] temp_reading = 16'sh1900;
  logic               module_reset_pin_n = 1'b1;
  logic               low_power_pin = 1'b0;
  logic               int_wire, int_out, int_oe_n, nv_write, pwm, spot_a, spot_b, cut;
  logic [15:0]        nv_in, nv_out;
  int                 n_mismatch = 0;
  int                 checked = 0;
  int                 cyc = 0;

  mptc_top dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .page_two_sel(page_two_sel), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_setting(power_setting),
    .power_override(power_override), .power_set(power_set), .temp_reading(temp_reading),
    .module_reset_pin_n(module_reset_pin_n), .low_power_pin(low_power_pin), .interrupt_pin_n_in(int_wire),
    .interrupt_pin_n_out(int_out), .interrupt_pin_n_oe_n(int_oe_n), .nv_count_in(nv_in), .nv_count_out(nv_out),
    .nv_write(nv_write), .heater_pwm(pwm), .heater_spot_a(spot_a), .heater_spot_b(spot_b), .cutoff_active(cut)
  );
  mptc_far_model far (.ref_clk(ref_clk), .nv_write(nv_write), .nv_count_out(nv_out), .nv_count_in(nv_in),
    .int_out(int_out), .int_oe_n(int_oe_n), .int_wire(int_wire));

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("byte %h", a), exp, reg_rdata);
  endtask
  task automatic sp_chk(input logic [7:0] exp);
    #1;
    chk("spots", exp, {6'h00, spot_b, spot_a});
  endtask
  task automatic pwm_chk(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (64) begin
      @(posedge ref_clk);
      #1;
      n = n + {7'h00, pwm};
    end
    chk("pwm high count", exp, n);
  endtask
  task automatic mod_reset();
    module_reset_pin_n <= 1'b0;
    tick(3);
    module_reset_pin_n <= 1'b1;
    tick(3);
  endtask

  task automatic t_count();
    rchk(8'h8D, 8'hFF);
    rchk(8'h8E, 8'h01);
    wr(8'h8D, 8'h55);
    rchk(8'h8D, 8'hFF);
    rchk(8'h80, 8'h00);
    tick(1);
    arst_n <= 1'b0;
    tick(3);
    arst_n <= 1'b1;
    tick(4);
    rchk(8'h8D, 8'h00);
    rchk(8'h8E, 8'h02);
    $display("test count done");
  endtask
  task automatic t_pins();
    tick(1);
    module_reset_pin_n <= 1'b0;
    tick(3);
    rchk(8'h91, 8'hFF);
    tick(1);
    module_reset_pin_n <= 1'b1;
    tick(3);
    rchk(8'h91, 8'h01);
    for (int i = 0; i < 2; i++) begin
      tick(1);
      low_power_pin <= i[0];
      tick(3);
      rchk(8'h92, {7'h00, i[0]});
    end
    wr(8'h93, 8'h00);
    tick(4);
    chk("pin wire", 8'h00, {7'h00, int_wire});
    rchk(8'h93, 8'h00);
    wr(8'h93, 8'h01);
    tick(4);
    rchk(8'h93, 8'h01);
    $display("test pins done");
  endtask
  task automatic t_heater();
    tick(1);
    low_power_pin <= 1'b0;
    power_setting <= 8'h20;
    tick(6);
    pwm_chk(8'h20);
    tick(1);
    low_power_pin <= 1'b1;
    tick(6);
    pwm_chk(8'h00);
    tick(1);
    power_override <= 1'b1;
    tick(6);
    pwm_chk(8'h20);
    tick(1);
    power_set <= 1'b1;
    low_power_pin <= 1'b0;
    tick(6);
    pwm_chk(8'h00);
    tick(1);
    power_override <= 1'b0;
    $display("test heater done");
  endtask
  task automatic t_cutoff();
    tick(1);
    power_setting <= 8'hC0;
    temp_reading <= 16'sh4FFF;
    tick(6);
    sp_chk(8'h03);
    tick(1);
    temp_reading <= 16'sh5000;
    tick(6);
    sp_chk(8'h00);
    chk("cut-off", 8'h01, {7'h00, cut});
    tick(1);
    temp_reading <= 16'sh4B01;
    tick(6);
    sp_chk(8'h00);
    tick(1);
    temp_reading <= 16'sh4B00;
    tick(6);
    sp_chk(8'h03);
    tick(1);
    temp_reading <= 16'shD800;
    tick(6);
    sp_chk(8'h03);
    chk("cold cut-off", 8'h00, {7'h00, cut});
    $display("test cut-off done");
  endtask
  task automatic t_stage();
    int n;
    tick(1);
    power_setting <= 8'h00;
    rchk(8'h8F, 8'h00);
    rchk(8'h90, 8'h00);
    wr(8'h90, 8'h01);
    rchk(8'h90, 8'h01);
    rchk(8'h8F, 8'h00);
    tick(1);
    power_setting <= 8'hC0;
    tick(3);
    sp_chk(8'h03);
    tick(1);
    power_setting <= 8'h00;
    mod_reset();
    power_setting <= 8'hC0;
    n = 0;
    while (spot_b !== 1'b1 && n < 300) begin
      tick(1);
      #1;
      n++;
    end
    chk("ramp time ok", 8'h01, {7'h00, n >= 80 && n <= 120});
    tick(80);
    sp_chk(8'h03);
    pwm_chk(8'h00);
    wr(8'h8F, 8'h00);
    wr(8'h90, 8'h00);
    tick(1);
    power_setting <= 8'h00;
    mod_reset();
    power_setting <= 8'hC0;
    tick(3);
    sp_chk(8'h03);
    $display("test staging done");
  endtask

  initial begin
    tick(20);
    arst_n <= 1'b1;
    tick(4);
    t_count();
    t_pins();
    t_heater();
    t_cutoff();
    t_stage();
    give_verdict();
  end
endmodule
